// ### pkg/audio_rx_pkg.sv
// Purpose: shared constants and types of the serial audio receiver
// Assumes: one 200 MHz clock for line, register and stream logic
// Notes:   byte offsets are the printed ones (all multiples of four)
package audio_rx_pkg;
  localparam int          CLOCK_MHZ      = 200;
  localparam int          CLOCK_PERIOD_NS = 1000 / CLOCK_MHZ;
  // register map
  localparam logic [7:0]  SOFT_RESET_OFF = 8'h40;
  localparam logic [7:0]  CONTROL_OFF    = 8'h44;
  localparam logic [7:0]  STATUS_OFF     = 8'h48;
  localparam logic [7:0]  USER_A_OFF     = 8'h64;
  localparam logic [7:0]  USER_A_LAST    = 8'h78;
  localparam logic [7:0]  USER_B_OFF     = 8'h7C;
  localparam logic [7:0]  USER_B_LAST    = 8'h90;
  localparam logic [31:0] SOFT_RESET_KEY = 32'h0000_000A;
  // control fields
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_FLUSH_BIT = 1;
  localparam int          CTRL_DIV_LSB   = 2;
  localparam int          CTRL_DIV_W     = 4;
  // transmit divisor codes and their ratios
  localparam logic [3:0]  DIV_CODE_LAST  = 4'h6;
  localparam logic [7:0]  DIV_RATIO [7]  = '{8'h04, 8'h08, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40};
  // line format
  localparam int          BLOCK_BITS     = 192;
  localparam int          WORD_BITS      = 32;
  localparam int          SUB_BITS       = 28;
  localparam int          UBIT_POS       = 25;
  localparam logic [7:0]  LAST_FRAME     = 8'hBF;
  localparam logic [4:0]  LAST_SLOT      = 5'h1B;
  localparam logic [9:0]  CNT_MAX        = 10'h3FF;
  localparam logic [7:0]  WIN_LAST       = 8'hFF;
  // sample buffer
  localparam int          FIFO_DEPTH     = 16;
  localparam int          FIFO_AW        = 4;
  localparam int          FIFO_W         = 32;
  typedef enum logic [1:0] {PRE_B, PRE_M, PRE_W} pre_t;
  typedef enum logic [2:0] {DS_IDLE, DS_PRE2, DS_PRE3, DS_PRE4, DS_BITS} dec_state_t;
endpackage

// ### rtl/biphase_decoder.sv
// Purpose: biphase-mark line decoder producing 28-bit subframe payloads
// Assumes: line input already passed two flip-flops
// Notes:   half-bit width learnt as the shortest interval per 256 edges
module biphase_decoder
  import audio_rx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              clear,
  input  wire logic              line,
  output logic                   sub_valid,
  output logic [SUB_BITS-1:0]    sub_data,
  output pre_t                   sub_pre,
  output logic [9:0]             bit_period
);
  typedef struct packed {
    logic                prev;
    logic [9:0]          cnt;
    logic [9:0]          minv;
    logic [7:0]          win;
    logic [9:0]          half;
    dec_state_t          st;
    pre_t                pre;
    logic                mid;
    logic [4:0]          nbits;
    logic [SUB_BITS-1:0] data;
    logic                valid;
  } dec_st_t;

  dec_st_t q, d;
  logic        edge_seen;
  logic [11:0] len2, h3, h5;
  logic        is_short, is_long, is_pre;

  always_comb begin
    edge_seen = line ^ q.prev;
    len2      = {1'b0, q.cnt, 1'b0};
    h3        = {2'b00, q.half} + {1'b0, q.half, 1'b0};
    h5        = {2'b00, q.half} + {q.half, 2'b00};
    is_short  = len2 < h3;
    is_long   = !is_short && (len2 < h5);
    is_pre    = !is_short && !is_long;
    d         = q;
    d.prev    = line;
    d.valid   = 1'b0;
    d.cnt     = (q.cnt == CNT_MAX) ? q.cnt : q.cnt + 10'h001;
    if (edge_seen) begin
      d.cnt = 10'h001;
      d.win = q.win + 8'h01;
      d.minv = (q.cnt < q.minv) ? q.cnt : q.minv;
      if (q.win == WIN_LAST) begin
        d.half = (q.cnt < q.minv) ? q.cnt : q.minv;
        d.minv = CNT_MAX;
      end
      if (q.half != 10'h000) begin
        case (q.st)
          DS_IDLE: if (is_pre) d.st = DS_PRE2;
          DS_PRE2: begin
            d.pre = is_short ? PRE_B : (is_long ? PRE_W : PRE_M);
            d.st  = DS_PRE3;
          end
          DS_PRE3: d.st = DS_PRE4;
          DS_PRE4: begin
            d.st    = DS_BITS;
            d.nbits = 5'h00;
            d.mid   = 1'b0;
          end
          DS_BITS: begin
            if (is_pre) begin
              d.st = DS_PRE2;
            end else if (is_long || q.mid) begin
              d.data  = {is_short, q.data[SUB_BITS-1:1]};
              d.mid   = 1'b0;
              d.nbits = q.nbits + 5'h01;
              if (q.nbits == LAST_SLOT) begin
                d.valid = 1'b1;
                d.st    = DS_IDLE;
              end
            end else begin
              d.mid = 1'b1;
            end
          end
          default: d.st = DS_IDLE;
        endcase
      end
    end
    if (clear) begin
      d       = '0;
      d.minv  = CNT_MAX;
      d.prev  = line;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sub_valid  = q.valid;
  assign sub_data   = q.data;
  assign sub_pre    = q.pre;
  assign bit_period = {q.half[8:0], 1'b0};
endmodule

// ### rtl/sample_fifo.sv
// Purpose: sample buffer between line decoder and output stream
// Assumes: writer cannot stall, so a full buffer drops the newest sample
// Notes:   flush empties the buffer without touching anything else
module sample_fifo
  import audio_rx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              flush,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire logic [FIFO_W-1:0] in_data,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic [FIFO_W-1:0]      out_data
);
  typedef struct packed {
    logic [FIFO_DEPTH-1:0][FIFO_W-1:0] mem;
    logic [FIFO_AW:0]                  wr;
    logic [FIFO_AW:0]                  rd;
  } fifo_st_t;

  fifo_st_t q, d;
  logic full, empty;

  always_comb begin
    empty     = q.wr == q.rd;
    full      = (q.wr[FIFO_AW] != q.rd[FIFO_AW]) && (q.wr[FIFO_AW-1:0] == q.rd[FIFO_AW-1:0]);
    in_ready  = !full;
    out_valid = !empty;
    out_data  = q.mem[q.rd[FIFO_AW-1:0]];
    d         = q;
    if (in_valid && !full) begin
      d.mem[q.wr[FIFO_AW-1:0]] = in_data;
      d.wr = q.wr + 1'b1;
    end
    if (out_ready && !empty) d.rd = q.rd + 1'b1;
    if (flush) begin
      d.wr = '0;
      d.rd = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ### rtl/audio_rx_user_capture.sv
// Purpose: serial audio receiver with user-data capture banks and register slave
// Assumes: line, register bus and stream share CLOCK; line input is asynchronous
// Notes:   user banks update once per complete 192-frame block

// Summary of operation
// - channel A user block held in six read-only words at 0x64..0x78
// - channel B user block held in six read-only words at 0x7C..0x90
// - banks update only when built as receiver with user registers enabled
// - word n of a bank holds user bits 32n+31 down to 32n
// - user words are read-only and read zero until data is captured
// - line, register and stream logic each run on their assigned clock
// - register reads and writes are handled on the register-bus clock
// - samples pass from line logic to stream through a buffer
// - transmit clock is a sample-rate multiple with a matching divisor programmed
// - bus reset returns the whole design to reset; soft reset does too, except the two line-input sync flops
// - stream reset clears only the buffer and stream logic
// - a control bit flushes the sample buffer alone
// - stereo up to 192 kHz, 32-bit subframe per channel
// - divisor codes 0..6 select ratios 4,8,16,24,32,48,64; others reserved
// - writing one to control bit 1 flushes the active buffer
// - control bit 0 enables the core; idle while zero
module audio_rx_user_capture
  import audio_rx_pkg::*;
#(
  parameter bit BUILD_RX     = 1'b1,
  parameter bit USER_REGS_EN = 1'b1
) (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        STREAM_RESETN,
  input  wire logic        AUDIO_IN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      M_AXIS_TDATA,
  output logic             M_AXIS_TVALID,
  input  wire logic        M_AXIS_TREADY
);
  typedef struct packed {
    logic                  sync1;
    logic                  sync2;
    logic                  bvalid;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic                  en;
    logic [CTRL_DIV_W-1:0] div;
    logic                  flush;
    logic                  sres;
    logic                  synced;
    logic [7:0]            frame;
    logic [BLOCK_BITS-1:0] sha;
    logic [BLOCK_BITS-1:0] shb;
    logic [BLOCK_BITS-1:0] ua;
    logic [BLOCK_BITS-1:0] ub;
  } top_st_t;

  top_st_t q, d;

  logic                  sub_valid;
  logic [SUB_BITS-1:0]   sub_data;
  pre_t                  sub_pre;
  logic [9:0]            bit_period;
  logic                  fifo_rst_n;
  logic                  wr_take;
  logic                  rd_take;
  logic [7:0]            rd_rel;
  logic [2:0]            rd_word;
  logic [31:0]           rd_val;
  logic                  chan_b;
  logic                  capture_on;
  logic                  dec_clear;
  logic [FIFO_W-1:0]     sample_word;

  // disabled core keeps the decoder idle
  assign dec_clear = !q.en || q.sres || !BUILD_RX;

  biphase_decoder u_dec (
    .clk        (CLOCK),
    .rst_n      (RESETN),
    .clear      (dec_clear),
    .line       (q.sync2),
    .sub_valid  (sub_valid),
    .sub_data   (sub_data),
    .sub_pre    (sub_pre),
    .bit_period (bit_period)
  );

  // stream reset touches only buffer and stream
  assign fifo_rst_n  = RESETN && STREAM_RESETN;
  assign chan_b      = sub_pre == PRE_W;
  assign sample_word = {2'b00, chan_b, sub_pre == PRE_B, sub_data};

  sample_fifo u_fifo (
    .clk       (CLOCK),
    .rst_n     (fifo_rst_n),
    .flush     (q.flush || q.sres),
    .in_valid  (sub_valid),
    .in_ready  (),
    .in_data   (sample_word),
    .out_valid (M_AXIS_TVALID),
    .out_ready (M_AXIS_TREADY),
    .out_data  (M_AXIS_TDATA)
  );

  // register slave on the bus clock
  always_comb begin
    wr_take       = S_AXI_AWVALID && S_AXI_WVALID && !q.bvalid;
    rd_take       = S_AXI_ARVALID && !q.rvalid;
    S_AXI_AWREADY = wr_take;
    S_AXI_WREADY  = wr_take;
    S_AXI_ARREADY = !q.rvalid;
    S_AXI_BVALID  = q.bvalid;
    S_AXI_BRESP   = 2'b00;
    S_AXI_RVALID  = q.rvalid;
    S_AXI_RRESP   = 2'b00;
    S_AXI_RDATA   = q.rdata;
  end

  // word n maps to bits 32n+31..32n
  always_comb begin
    rd_rel  = 8'h00;
    rd_word = 3'h0;
    rd_val  = 32'h0000_0000;
    if (S_AXI_ARADDR >= USER_A_OFF && S_AXI_ARADDR <= USER_A_LAST) begin
      rd_rel  = S_AXI_ARADDR - USER_A_OFF;
      rd_word = rd_rel[4:2];
      rd_val  = q.ua[rd_word * WORD_BITS +: WORD_BITS];
    end else if (S_AXI_ARADDR >= USER_B_OFF && S_AXI_ARADDR <= USER_B_LAST) begin
      rd_rel  = S_AXI_ARADDR - USER_B_OFF;
      rd_word = rd_rel[4:2];
      rd_val  = q.ub[rd_word * WORD_BITS +: WORD_BITS];
    end else if (S_AXI_ARADDR == CONTROL_OFF) begin
      rd_val[CTRL_EN_BIT] = q.en;
      rd_val[CTRL_DIV_LSB +: CTRL_DIV_W] = q.div;
    end else if (S_AXI_ARADDR == STATUS_OFF) begin
      rd_val[9:0] = bit_period;
    end
  end

  assign capture_on = BUILD_RX && USER_REGS_EN && q.en;

  always_comb begin
    d       = q;
    d.sync1 = AUDIO_IN;
    d.sync2 = q.sync1;
    d.flush = 1'b0;
    d.sres  = 1'b0;
    if (q.bvalid && S_AXI_BREADY) d.bvalid = 1'b0;
    if (q.rvalid && S_AXI_RREADY) d.rvalid = 1'b0;
    if (rd_take) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
    end
    // writes to user words are ignored
    if (wr_take) begin
      d.bvalid = 1'b1;
      if (S_AXI_AWADDR == CONTROL_OFF && S_AXI_WSTRB[0]) begin
        d.en    = S_AXI_WDATA[CTRL_EN_BIT];
        d.flush = S_AXI_WDATA[CTRL_FLUSH_BIT];
        if (S_AXI_WDATA[CTRL_DIV_LSB +: CTRL_DIV_W] <= DIV_CODE_LAST)
          d.div = S_AXI_WDATA[CTRL_DIV_LSB +: CTRL_DIV_W];
      end
      if (S_AXI_AWADDR == SOFT_RESET_OFF && S_AXI_WDATA == SOFT_RESET_KEY) d.sres = 1'b1;
    end
    // capture gated by build and enable
    if (capture_on && sub_valid) begin
      if (sub_pre == PRE_B) begin
        d.synced  = 1'b1;
        d.frame   = 8'h00;
        d.sha[0]  = sub_data[UBIT_POS];
      end else if (sub_pre == PRE_M && q.synced) begin
        d.sha[q.frame] = sub_data[UBIT_POS];
      end else if (chan_b && q.synced) begin
        d.shb[q.frame] = sub_data[UBIT_POS];
        d.frame        = q.frame + 8'h01;
        if (q.frame == LAST_FRAME) begin
          d.ua     = q.sha;
          d.ub     = q.shb;
          d.ub[LAST_FRAME] = sub_data[UBIT_POS];
          d.synced = 1'b0;
        end
      end
    end
    if (q.sres) begin
      d        = '0;
      d.sync1  = q.sync1;
      d.sync2  = q.sync2;
    end
  end

  // single clock serves all three roles here
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ### tb/audio_rx_chk.sv
// Purpose: port-level assertions for the user capture receiver
// Assumes: one clock domain, RESETN asynchronous
// Notes:   a write may legally cut a pending response or drain the buffer, so holds skip it
module audio_rx_chk
  import audio_rx_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        STREAM_RESETN,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] M_AXIS_TDATA,
  input wire logic        M_AXIS_TVALID,
  input wire logic        M_AXIS_TREADY
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  a_write_answer: assert property (
    S_AXI_AWREADY |=> S_AXI_BVALID && S_AXI_BRESP == 2'h0)
    else $error("write not answered in the next cycle");
  a_write_gate: assert property (
    S_AXI_AWREADY |-> S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_BVALID)
    else $error("write taken without both valids or while answering");
  a_wready_pair: assert property (S_AXI_WREADY == S_AXI_AWREADY)
    else $error("address ready and data ready differ");
  a_bresp_hold: assert property (
    S_AXI_BVALID && !S_AXI_BREADY && !$past(S_AXI_AWREADY) |=> S_AXI_BVALID)
    else $error("write response dropped before acceptance");
  a_read_answer: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RRESP == 2'h0)
    else $error("read not answered in the next cycle");
  a_read_gate: assert property (S_AXI_ARREADY == !S_AXI_RVALID)
    else $error("read address ready not the inverse of read valid");
  a_rdata_hold: assert property (
    S_AXI_RVALID && !S_AXI_RREADY && !$past(S_AXI_AWREADY) |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data changed before acceptance");
  a_read_release: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read valid stayed after acceptance");
  a_soft_clear: assert property (
    S_AXI_AWREADY && S_AXI_AWADDR == SOFT_RESET_OFF && S_AXI_WDATA == SOFT_RESET_KEY |-> ##2 !M_AXIS_TVALID)
    else $error("soft reset left the buffer non-empty");
  a_flush_empty: assert property (
    S_AXI_AWREADY && S_AXI_AWADDR == CONTROL_OFF && S_AXI_WSTRB[0] && S_AXI_WDATA[CTRL_FLUSH_BIT]
    |-> ##[1:3] !M_AXIS_TVALID)
    else $error("flush did not empty the buffer");
  a_stream_reset: assert property (!STREAM_RESETN |-> !M_AXIS_TVALID)
    else $error("stream valid during stream reset");
  a_stream_hold: assert property (disable iff (!RESETN || !STREAM_RESETN)
    M_AXIS_TVALID && !M_AXIS_TREADY && !S_AXI_AWREADY && !$past(S_AXI_AWREADY)
    |=> M_AXIS_TVALID && $stable(M_AXIS_TDATA))
    else $error("stream word changed before acceptance");
endmodule

bind audio_rx_user_capture audio_rx_chk chk (
  .CLOCK(CLOCK), .RESETN(RESETN), .STREAM_RESETN(STREAM_RESETN),
  .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .M_AXIS_TDATA(M_AXIS_TDATA), .M_AXIS_TVALID(M_AXIS_TVALID),
  .M_AXIS_TREADY(M_AXIS_TREADY)
);

// ### tb/line_source.sv
// Purpose: biphase-mark line source sending lead frames, one user block and a tail frame
// Assumes: line changes on falling clk edges, half-bit of HALF clocks
// Notes:   far faster than 1024 clocks per frame, traded so one block fits a short run
module line_source #(
  // about 384 clocks a frame, under the 1024 floor, so one block fits the run
  parameter int HALF = 3,
  parameter int LEAD = 8
) (
  input  wire logic clk,
  input  wire logic start,
  output logic      line,
  output logic      done
);
  timeunit 1ns;
  timeprecision 1ps;

  task automatic half(input logic v);
    line = v;
    repeat (HALF) @(negedge clk);
  endtask

  task automatic sub(input logic [7:0] pre, input logic [26:0] d);
    logic lv;
    lv = line;
    for (int i = 7; i >= 0; i--) half(pre[i] ^ lv);
    for (int i = 0; i < 28; i++) begin
      half(!line);
      half(((i == 27) ? ^d : d[i]) ? !line : line);
    end
  endtask

  initial begin
    line = 1'b0;
    done = 1'b0;
    wait (start);
    @(negedge clk);
    for (int f = -LEAD; f < 193; f++) begin
      sub((f == 0) ? 8'hE8 : 8'hE2, {1'b0, f % 3 == 0, 1'b0, 24'(f)});
      sub(8'hE4, {1'b0, f % 5 == 1, 1'b0, ~24'(f)});
    end
    done = 1'b1;
  end
endmodule

// ### tb/tb_audio_rx_user_capture.sv
// Purpose: register-level tests of user capture, flush, stream reset and soft reset
// Assumes: inputs change on falling edges; partner sends one user block
// Notes:   the tail frame after the block only closes the last subframe
module tb_audio_rx_user_capture
  import audio_rx_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, resetn, stream_resetn, start, awvalid, wvalid, bready, arvalid, rready, tready;
  logic        audio_line, src_done, awready, wready, bvalid, arready, rvalid, tvalid;
  logic [7:0]  awaddr, araddr;
  logic [1:0]  bresp, rresp;
  logic [31:0] wdata, rdata, tdata, seen;
  logic [31:0] bs_word = 32'h0;
  int          err_count = 0, total_checks = 0, cycles = 0;

  audio_rx_user_capture dut (
    .CLOCK(clock), .RESETN(resetn), .STREAM_RESETN(stream_resetn), .AUDIO_IN(audio_line),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .M_AXIS_TDATA(tdata), .M_AXIS_TVALID(tvalid), .M_AXIS_TREADY(tready)
  );
  line_source src (.clk(clock), .start(start), .line(audio_line), .done(src_done));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // hang guard: the line run (one block plus lead and tail frames) is about 77000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (tvalid && tready && tdata[28]) bs_word <= tdata;
    if (cycles == 95000) begin
      err_count++;
      test_done();
    end
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // late ready lets the hold check see a waiting response; soft reset drops it, so no lag there
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit late = 1'b1);
    awaddr = a;
    wdata = d;
    awvalid = 1'b1;
    wvalid = 1'b1;
    do @(posedge clock); while (!awready);
    @(negedge clock);
    awvalid = 1'b0;
    wvalid = 1'b0;
    if (late) repeat (2) @(negedge clock);
    bready = 1'b1;
    do @(posedge clock); while (!bvalid);
    @(negedge clock);
    bready = 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    araddr = a; arvalid = 1'b1;
    while (!arready) @(negedge clock);
    @(negedge clock); arvalid = 1'b0;
    @(negedge clock); rready = 1'b1;
    while (!rvalid) @(negedge clock);
    seen = rdata;
    @(negedge clock); rready = 1'b0;
    check($sformatf("register %h", a), seen, exp);
  endtask

  function automatic logic [31:0] uword(bit chb, int n);
    for (int i = 0; i < 32; i++) uword[i] = chb ? ((32 * n + i) % 5 == 1) : ((32 * n + i) % 3 == 0);
  endfunction

  initial begin
    {resetn, stream_resetn, start, awvalid, wvalid, bready, arvalid, rready, tready} = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    repeat (20) @(negedge clock);
    resetn = 1'b1;
    stream_resetn = 1'b1;
    for (int i = 0; i < 12; i++) rchk(USER_A_OFF + 8'(4 * i), 32'h0);
    wr(USER_A_OFF, 32'hFFFF_FFFF);
    rchk(USER_A_OFF, 32'h0);
    rchk(8'hA0, 32'h0);
    $display("test reset_values done");
    for (int c = 0; c < 7; c++) begin
      wr(CONTROL_OFF, 32'(c) << CTRL_DIV_LSB);
      rchk(CONTROL_OFF, 32'(c) << CTRL_DIV_LSB);
    end
    wr(CONTROL_OFF, 32'h0000_003C);
    rchk(CONTROL_OFF, 32'h0000_0018);
    $display("test divisor_codes done");
    wr(CONTROL_OFF, 32'h0000_0001);
    start = 1'b1;
    while (!tvalid) @(negedge clock);
    wr(CONTROL_OFF, 32'h0000_0003);
    check("flushed stream valid", 32'(tvalid), 32'h0);
    rchk(CONTROL_OFF, 32'h0000_0001);
    while (!tvalid) @(negedge clock);
    stream_resetn = 1'b0;
    @(negedge clock);
    check("stream valid in stream reset", 32'(tvalid), 32'h0);
    stream_resetn = 1'b1;
    rchk(CONTROL_OFF, 32'h0000_0001);
    tready = 1'b1;
    $display("test flush_and_stream_reset done");
    while (!src_done) @(negedge clock);
    repeat (400) @(negedge clock);
    for (int i = 0; i < 6; i++) begin
      rchk(USER_A_OFF + 8'(4 * i), uword(1'b0, i));
      rchk(USER_B_OFF + 8'(4 * i), uword(1'b1, i));
    end
    check("block start word", bs_word, 32'h1A00_0000);
    // a half-bit of three clocks from the source gives a six-clock bit period
    rchk(STATUS_OFF, 32'h0000_0006);
    $display("test user_capture done");
    wr(SOFT_RESET_OFF, SOFT_RESET_KEY, 1'b0);
    rchk(USER_B_OFF, 32'h0);
    rchk(CONTROL_OFF, 32'h0);
    $display("test soft_reset done");
    test_done();
  end
endmodule
